// ### design/ram_pkg.sv
// ======================================================================
// Shared constants and types for the first reference input bank.
package ram_pkg;

	// Register indices; the byte address on the bus is four times these.
	localparam logic [9:0] IDX_LOGIC = 10'h300;
	localparam logic [9:0] IDX_DIV_B0 = 10'h301;
	localparam logic [9:0] IDX_DIV_B1 = 10'h302;
	localparam logic [9:0] IDX_DIV_B2 = 10'h303;
	localparam logic [9:0] IDX_PER_B0 = 10'h304;
	localparam logic [9:0] IDX_PER_B1 = 10'h305;
	localparam logic [9:0] IDX_PER_B2 = 10'h306;
	localparam logic [9:0] IDX_PER_B3 = 10'h307;
	localparam logic [9:0] IDX_PER_B4 = 10'h308;
	localparam logic [9:0] IDX_INNER_B0 = 10'h309;
	localparam logic [9:0] IDX_INNER_B1 = 10'h30A;
	localparam logic [9:0] IDX_INNER_B2 = 10'h30B;
	localparam logic [9:0] IDX_OUTER_B0 = 10'h30C;
	localparam logic [9:0] IDX_OUTER_B1 = 10'h30D;
	localparam logic [9:0] IDX_OUTER_B2 = 10'h30E;
	localparam logic [9:0] IDX_VTIME_B0 = 10'h30F;
	localparam logic [9:0] IDX_VTIME_B1 = 10'h310;
	localparam logic [9:0] IDX_PTHR_B0 = 10'h311;
	localparam logic [9:0] IDX_PTHR_B1 = 10'h312;
	localparam logic [9:0] IDX_PTHR_B2 = 10'h313;
	localparam logic [9:0] IDX_PFILL = 10'h314;
	localparam logic [9:0] IDX_PDRAIN = 10'h315;
	localparam logic [9:0] IDX_FTHR_B0 = 10'h316;
	localparam logic [9:0] IDX_FTHR_B1 = 10'h317;
	localparam logic [9:0] IDX_FTHR_B2 = 10'h318;
	localparam logic [9:0] IDX_FFILL = 10'h319;
	localparam logic [9:0] IDX_FDRAIN = 10'h31A;
	localparam logic [9:0] IDX_STATUS = 10'h31C;
	localparam logic [9:0] IDX_IRQ_CLR = 10'h31D;
	localparam logic [9:0] IDX_IRQ_EN = 10'h31E;

	// Field positions in the receiver select register.
	localparam int DIV2_BIT = 3;
	localparam int FAM_MSB = 1;
	localparam logic [1:0] FAM_DIFF = 2'h0;

	// Reset values and writable bit masks of the configuration bytes.
	localparam logic [7:0] REG_RST_C [IDX_LOGIC:IDX_FDRAIN] = '{
		8'h00, 8'hCF, 8'h00, 8'h00, 8'hC9, 8'hEA, 8'h10, 8'h03, 8'h00,
		8'h14, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h0A, 8'h00,
		8'hBC, 8'h02, 8'h00, 8'h0A, 8'h0A, 8'hBC, 8'h02, 8'h00,
		8'h0A, 8'h0A};
	localparam logic [7:0] REG_MASK_C [IDX_LOGIC:IDX_FDRAIN] = '{
		8'h0B, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF};

	// Status bit positions.
	localparam int ST_FAULT = 0;
	localparam int ST_VALID_UP = 1;
	localparam int ST_VALID_DN = 2;
	localparam int ST_PLOCK_UP = 3;
	localparam int ST_PLOCK_DN = 4;
	localparam int ST_FLOCK_UP = 5;
	localparam int ST_FLOCK_DN = 6;
	localparam int ST_W = 7;

	// Timing: one millisecond of the validation timer.
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

	// Lock detector accumulator full scale.
	localparam logic [15:0] ACC_FULL_C = 16'h0400;

	typedef struct packed {
		logic [23:0] thr;
		logic [7:0] fill;
		logic [7:0] drain;
	} ram_lock_cfg_t;

	typedef struct packed {
		logic div2_en;
		logic [1:0] family;
		logic [19:0] rdiv;
		logic [39:0] nom_period;
		logic [19:0] inner_tol;
		logic [19:0] outer_tol;
		logic [15:0] valid_time;
		ram_lock_cfg_t phase;
		ram_lock_cfg_t freq;
	} ram_cfg_t;

endpackage

// ### design/ram_ref_monitor.sv
`timescale 1ns/10ps
// ======================================================================
// First reference input: configuration bank, monitor and lock detectors.
module ram_ref_monitor #(
	parameter int MS_CYCLES = ram_pkg::MS_CYCLES
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reference receiver pins and conditioned reference.
	input wire logic ref_true,
	input wire logic ref_comp,
	output logic ref_out,
	// Lock detector measurements, one per phase detector tick.
	input wire logic pd_tick,
	input wire logic [23:0] phase_err_ps,
	input wire logic [23:0] freq_err_ps,
	// Measured reference period.
	input wire logic meas_strobe,
	input wire logic [39:0] meas_period_fs,
	// Configuration and state towards the loop.
	output ram_pkg::ram_cfg_t cfg,
	output logic ref_valid,
	output logic freq_fault,
	output logic phase_lock,
	output logic freq_lock,
	output logic irq
);

	// ==================================================================
	// Helper functions.

	// One lock detector step: fill below threshold, else drain.
	function automatic logic [15:0] lock_step(input logic [15:0] acc,
		input logic [23:0] err, input ram_pkg::ram_lock_cfg_t c);
		logic [16:0] sum;
		sum = {1'b0, acc} + {9'h000, c.fill};
		if (err < c.thr) begin
			lock_step = (sum > {1'b0, ram_pkg::ACC_FULL_C}) ?
				ram_pkg::ACC_FULL_C : sum[15:0];
		end else begin
			lock_step = (acc > {8'h00, c.drain}) ?
				acc - {8'h00, c.drain} : 16'h0000;
		end
	endfunction

	// Lock flag from the next accumulator value, with hysteresis.
	function automatic logic lock_flag(input logic [15:0] acc,
		input logic cur);
		if (acc == ram_pkg::ACC_FULL_C) begin
			lock_flag = 1'b1;
		end else if (acc == 16'h0000) begin
			lock_flag = 1'b0;
		end else begin
			lock_flag = cur;
		end
	endfunction

	// True when deviation exceeds nominal divided by the tolerance code.
	function automatic logic dev_beyond(input logic [39:0] dev,
		input logic [19:0] tol, input logic [39:0] nom);
		logic [59:0] prod;
		prod = {20'h0_0000, dev} * {40'h00_0000_0000, tol};
		dev_beyond = prod > {20'h0_0000, nom};
	endfunction

	// ==================================================================
	// Registers.
	logic [7:0] regs_ff [ram_pkg::IDX_LOGIC:ram_pkg::IDX_FDRAIN];
	logic [ram_pkg::ST_W-1:0] status_ff, nxt_status;
	logic [ram_pkg::ST_W-1:0] irq_en_ff;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, pslverr_ff, nxt_pslverr;
	ram_pkg::ram_cfg_t cfg_ff;
	logic rx_ff, div_ff, ref_out_ff, nxt_ref_out, nxt_div;
	logic [17:0] ms_cnt_ff;
	logic [15:0] vms_cnt_ff;
	logic valid_ff, nxt_valid, fault_ff, nxt_fault;
	logic [15:0] pacc_ff, facc_ff, nxt_pacc, nxt_facc;
	logic plock_ff, flock_ff, nxt_plock, nxt_flock;
	logic irq_ff;

	// ==================================================================
	// APB decode.
	logic [9:0] idx;
	logic access, wr_done, rd_done, cfg_hit, own_hit, aligned;
	logic [7:0] cfg_rd;
	ram_pkg::ram_cfg_t cfg_dec;

	// Address decode; the access phase always takes two cycles.
	assign idx = paddr[11:2];
	assign aligned = paddr[1:0] == 2'b00;
	assign access = psel && penable && !pready_ff;
	assign wr_done = psel && penable && pready_ff && pwrite &&
		!pslverr_ff;
	assign rd_done = psel && penable && pready_ff && !pwrite;
	assign cfg_hit = aligned && idx >= ram_pkg::IDX_LOGIC &&
		idx <= ram_pkg::IDX_FDRAIN;
	assign own_hit = aligned && (idx == ram_pkg::IDX_STATUS ||
		idx == ram_pkg::IDX_IRQ_CLR || idx == ram_pkg::IDX_IRQ_EN);
	assign cfg_rd = cfg_hit ? regs_ff[idx] : 8'h00;
	assign nxt_pslverr = !(cfg_hit || own_hit);

	// Read data selection; the clear register reads as zero.
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (cfg_hit) begin
			nxt_prdata[7:0] = cfg_rd;
		end else if (idx == ram_pkg::IDX_STATUS && aligned) begin
			nxt_prdata[ram_pkg::ST_W-1:0] = status_ff;
		end else if (idx == ram_pkg::IDX_IRQ_EN && aligned) begin
			nxt_prdata[ram_pkg::ST_W-1:0] = irq_en_ff;
		end
	end

	// Bus answer registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= access;
			pslverr_ff <= access && nxt_pslverr;
			prdata_ff <= (access && !pwrite) ? nxt_prdata : prdata_ff;
		end
	end

	// Configuration bytes; reserved bits are masked off on write.
	// divider storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = ram_pkg::IDX_LOGIC; i <= ram_pkg::IDX_FDRAIN;
				i++) begin
				regs_ff[i] <= ram_pkg::REG_RST_C[i];
			end
		end else begin
			for (int i = ram_pkg::IDX_LOGIC; i <= ram_pkg::IDX_FDRAIN;
				i++) begin
				if (wr_done && idx == 10'(i)) begin
					regs_ff[i] <= pwdata[7:0] & ram_pkg::REG_MASK_C[i];
				end
			end
		end
	end

	// Byte fields gathered into the configuration word, LSB first.
	// period assembly
	assign cfg_dec.div2_en = regs_ff[ram_pkg::IDX_LOGIC][ram_pkg::DIV2_BIT];
	assign cfg_dec.family = regs_ff[ram_pkg::IDX_LOGIC][ram_pkg::FAM_MSB:0];
	assign cfg_dec.rdiv = {regs_ff[ram_pkg::IDX_DIV_B2][3:0],
		regs_ff[ram_pkg::IDX_DIV_B1], regs_ff[ram_pkg::IDX_DIV_B0]};
	assign cfg_dec.nom_period = {regs_ff[ram_pkg::IDX_PER_B4],
		regs_ff[ram_pkg::IDX_PER_B3], regs_ff[ram_pkg::IDX_PER_B2],
		regs_ff[ram_pkg::IDX_PER_B1], regs_ff[ram_pkg::IDX_PER_B0]};
	assign cfg_dec.inner_tol = {regs_ff[ram_pkg::IDX_INNER_B2][3:0],
		regs_ff[ram_pkg::IDX_INNER_B1], regs_ff[ram_pkg::IDX_INNER_B0]};
	assign cfg_dec.outer_tol = {regs_ff[ram_pkg::IDX_OUTER_B2][3:0],
		regs_ff[ram_pkg::IDX_OUTER_B1], regs_ff[ram_pkg::IDX_OUTER_B0]};
	assign cfg_dec.valid_time = {regs_ff[ram_pkg::IDX_VTIME_B1],
		regs_ff[ram_pkg::IDX_VTIME_B0]};
	assign cfg_dec.phase.thr = {regs_ff[ram_pkg::IDX_PTHR_B2],
		regs_ff[ram_pkg::IDX_PTHR_B1], regs_ff[ram_pkg::IDX_PTHR_B0]};
	assign cfg_dec.phase.fill = regs_ff[ram_pkg::IDX_PFILL];
	assign cfg_dec.phase.drain = regs_ff[ram_pkg::IDX_PDRAIN];
	assign cfg_dec.freq.thr = {regs_ff[ram_pkg::IDX_FTHR_B2],
		regs_ff[ram_pkg::IDX_FTHR_B1], regs_ff[ram_pkg::IDX_FTHR_B0]};
	assign cfg_dec.freq.fill = regs_ff[ram_pkg::IDX_FFILL];
	assign cfg_dec.freq.drain = regs_ff[ram_pkg::IDX_FDRAIN];

	// ==================================================================
	// Receiver and divide-by-2.
	logic rx_level, cmos_sel;

	assign cmos_sel = cfg_ff.family != ram_pkg::FAM_DIFF;
	assign rx_level = cmos_sel ? ref_true : (ref_true && !ref_comp);
	assign nxt_div = (rx_level && !rx_ff) ? !div_ff : div_ff;
	assign nxt_ref_out = cfg_ff.div2_en ? nxt_div : rx_level;

	// Receiver path registers and configuration copy.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ff <= 1'b0;
			div_ff <= 1'b0;
			ref_out_ff <= 1'b0;
			cfg_ff <= '0;
		end else begin
			rx_ff <= rx_level;
			div_ff <= nxt_div;
			ref_out_ff <= nxt_ref_out;
			cfg_ff <= cfg_dec;
		end
	end

	// ==================================================================
	// Frequency monitor and validation timer.
	logic [39:0] dev;
	logic ms_tick;

	assign dev = (meas_period_fs > cfg_ff.nom_period) ?
		meas_period_fs - cfg_ff.nom_period :
		cfg_ff.nom_period - meas_period_fs;
	assign nxt_fault = !meas_strobe ? fault_ff :
		fault_ff ? dev_beyond(dev, cfg_ff.inner_tol, cfg_ff.nom_period) :
		dev_beyond(dev, cfg_ff.outer_tol, cfg_ff.nom_period);
	assign ms_tick = ms_cnt_ff == 18'(MS_CYCLES - 1);
	// validation delay
	// The limit comes from the register bytes, which hold their reset value
	// at once; the copy in cfg_ff is still zero on the first edge.
	assign nxt_valid = !nxt_fault && (valid_ff ||
		vms_cnt_ff >= cfg_dec.valid_time);

	// Fault flag, millisecond prescaler and validation count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff <= 1'b0;
			valid_ff <= 1'b0;
			ms_cnt_ff <= 18'h0_0000;
			vms_cnt_ff <= 16'h0000;
		end else begin
			fault_ff <= nxt_fault;
			valid_ff <= nxt_valid;
			ms_cnt_ff <= ms_tick ? 18'h0_0000 : ms_cnt_ff + 18'h0_0001;
			if (nxt_fault) begin
				vms_cnt_ff <= 16'h0000;
			end else if (ms_tick && vms_cnt_ff != 16'hFFFF) begin
				vms_cnt_ff <= vms_cnt_ff + 16'h0001;
			end
		end
	end

	// ==================================================================
	// Lock detectors.
	// phase fill
	assign nxt_pacc = pd_tick ?
		lock_step(pacc_ff, phase_err_ps, cfg_ff.phase) : pacc_ff;
	assign nxt_facc = pd_tick ?
		lock_step(facc_ff, freq_err_ps, cfg_ff.freq) : facc_ff;
	assign nxt_plock = lock_flag(nxt_pacc, plock_ff);
	assign nxt_flock = lock_flag(nxt_facc, flock_ff);

	// Accumulators and lock flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pacc_ff <= 16'h0000;
			facc_ff <= 16'h0000;
			plock_ff <= 1'b0;
			flock_ff <= 1'b0;
		end else begin
			pacc_ff <= nxt_pacc;
			facc_ff <= nxt_facc;
			plock_ff <= nxt_plock;
			flock_ff <= nxt_flock;
		end
	end

	// ==================================================================
	// Interrupt status; a new event wins over a clear in the same cycle.
	logic [ram_pkg::ST_W-1:0] events, clr_bits, nxt_irq_en;

	assign events[ram_pkg::ST_FAULT] = nxt_fault && !fault_ff;
	assign events[ram_pkg::ST_VALID_UP] = nxt_valid && !valid_ff;
	assign events[ram_pkg::ST_VALID_DN] = !nxt_valid && valid_ff;
	assign events[ram_pkg::ST_PLOCK_UP] = nxt_plock && !plock_ff;
	assign events[ram_pkg::ST_PLOCK_DN] = !nxt_plock && plock_ff;
	assign events[ram_pkg::ST_FLOCK_UP] = nxt_flock && !flock_ff;
	assign events[ram_pkg::ST_FLOCK_DN] = !nxt_flock && flock_ff;
	assign clr_bits = (wr_done && idx == ram_pkg::IDX_IRQ_CLR) ?
		pwdata[ram_pkg::ST_W-1:0] : '0;
	assign nxt_status = (status_ff & ~clr_bits) | events;
	// A new enable mask acts on the interrupt in the same cycle.
	assign nxt_irq_en = (wr_done && idx == ram_pkg::IDX_IRQ_EN) ?
		pwdata[ram_pkg::ST_W-1:0] : irq_en_ff;

	// Status, enable and interrupt output.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= '0;
			irq_en_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			irq_en_ff <= nxt_irq_en;
			irq_ff <= |(nxt_status & nxt_irq_en);
		end
	end

	// Output drive.
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign ref_out = ref_out_ff;
	assign cfg = cfg_ff;
	assign ref_valid = valid_ff;
	assign freq_fault = fault_ff;
	assign phase_lock = plock_ff;
	assign freq_lock = flock_ff;
	assign irq = irq_ff;

	// ==================================================================
	// Assertions.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence logic_wr_s;
		wr_done && idx == ram_pkg::IDX_LOGIC;
	endsequence

	div2_bypass_a: assert property (
		!cfg_ff.div2_en |=> ref_out_ff == $past(rx_level))
		else $error("bypassed reference does not follow receiver");
	family_cfg_a: assert property (
		logic_wr_s |-> ##2 cfg_ff.family == $past(pwdata[1:0], 2))
		else $error("receiver family not taken from write");
	cmos_pin_a: assert property (
		(cmos_sel && !cfg_ff.div2_en) |=> ref_out_ff == $past(ref_true))
		else $error("CMOS mode does not use only the true pin");
	div_hi_zero_a: assert property (
		rd_done && cfg_hit && idx == ram_pkg::IDX_DIV_B2 |->
		prdata_ff[31:4] == 28'h000_0000)
		else $error("divider upper reserved bits not zero");
	valid_delay_a: assert property (
		$rose(valid_ff) |-> $past(vms_cnt_ff) >= $past(cfg_dec.valid_time))
		else $error("input declared valid before the timer ran out");
	fault_drop_a: assert property (
		fault_ff |-> !valid_ff)
		else $error("input valid while faulted");
	pfill_step_a: assert property (
		pd_tick && phase_err_ps < cfg_ff.phase.thr &&
		{1'b0, pacc_ff} + {9'h000, cfg_ff.phase.fill} <=
		{1'b0, ram_pkg::ACC_FULL_C} |=>
		pacc_ff == $past(pacc_ff) + {8'h00, $past(cfg_ff.phase.fill)})
		else $error("phase accumulator did not fill by the rate");
	pdrain_step_a: assert property (
		pd_tick && phase_err_ps >= cfg_ff.phase.thr &&
		pacc_ff > {8'h00, cfg_ff.phase.drain} |=>
		pacc_ff == $past(pacc_ff) - {8'h00, $past(cfg_ff.phase.drain)})
		else $error("phase accumulator did not drain by the rate");
	lock_full_a: assert property (
		pacc_ff == ram_pkg::ACC_FULL_C |-> plock_ff)
		else $error("phase lock not set at full accumulator");
	unlock_empty_a: assert property (
		facc_ff == 16'h0000 |-> !flock_ff)
		else $error("frequency lock held at empty accumulator");
	fault_set_a: assert property (
		meas_strobe && !fault_ff &&
		dev_beyond(dev, cfg_ff.outer_tol, cfg_ff.nom_period) |=> fault_ff)
		else $error("fault not raised beyond outer tolerance");
	irq_level_a: assert property (
		irq_ff == |(status_ff & irq_en_ff))
		else $error("interrupt level differs from enabled status bits");

endmodule // ram_ref_monitor

// ### verif/ram_ref_source.sv
`timescale 1ns/10ps
// ======================================================================
// Reference source: a square wave on the true pin while run is high.
module ram_ref_source #(
	parameter int HALF = 4
) (
	// Clock and control.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic comp_same,
	// Receiver pins.
	output logic ref_true,
	output logic ref_comp
);
	int cnt_ff;
	logic lvl_ff;

	// Toggle every HALF cycles; the source stands still low between runs.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 0;
			lvl_ff <= 1'b0;
		end else if (!run) begin
			cnt_ff <= 0;
			lvl_ff <= 1'b0;
		end else if (cnt_ff == HALF - 1) begin
			cnt_ff <= 0;
			lvl_ff <= ~lvl_ff;
		end else begin
			cnt_ff <= cnt_ff + 1;
		end
	end

	// The complement may copy the true pin to expose use of it.
	assign ref_true = lvl_ff;
	assign ref_comp = comp_same ? lvl_ff : ~lvl_ff;
endmodule // ram_ref_source

// ### verif/test_ref_input_a_monitor_config.sv
`timescale 1ns/10ps
// ======================================================================
// Self-checking bench for the first reference input bank.
`define chk(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	err_total++; $display("unexpected at %0t: got %h exp %h", \
	$time, (a), (e)); end end
module test_ref_input_a_monitor_config;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic ref_true, ref_comp, ref_out, ref_out_d, pd_tick, meas_strobe;
	logic [23:0] phase_err_ps, freq_err_ps;
	logic [39:0] meas_period_fs;
	logic [39:0] nom = 40'h00_0310_EAC9;
	ram_pkg::ram_cfg_t cfg;
	logic ref_valid, freq_fault, phase_lock, freq_lock, irq;
	logic rerr, src_run, src_comp;
	int rises, err_total, samples_checked;

	ram_ref_monitor #(.MS_CYCLES(10)) i_ram_ref_monitor (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_true(ref_true),
		.ref_comp(ref_comp), .ref_out(ref_out), .pd_tick(pd_tick),
		.phase_err_ps(phase_err_ps), .freq_err_ps(freq_err_ps),
		.meas_strobe(meas_strobe), .meas_period_fs(meas_period_fs),
		.cfg(cfg), .ref_valid(ref_valid), .freq_fault(freq_fault),
		.phase_lock(phase_lock), .freq_lock(freq_lock), .irq(irq));
	ram_ref_source #(.HALF(4)) i_ram_ref_source (.pclk(pclk),
		.presetn(presetn), .run(src_run), .comp_same(src_comp),
		.ref_true(ref_true), .ref_comp(ref_comp));

	// Clock and counting of conditioned reference rising edges.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		ref_out_d <= ref_out;
		if (ref_out && !ref_out_d) rises <= rises + 1;
	end

	task end_sim;
		if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// One APB transfer, entered just after a rising edge.
	task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task ticks(input int n, input logic [23:0] e);
		repeat (n) begin
			pd_tick <= 1'b1;
			phase_err_ps <= e;
			freq_err_ps <= e;
			@(posedge pclk);
		end
		pd_tick <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	task meas(input logic [39:0] p);
		meas_strobe <= 1'b1;
		meas_period_fs <= p;
		@(posedge pclk);
		meas_strobe <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	// Reset values in the registers and on the configuration outputs.
	task t_reset;
		@(posedge pclk);
		`chk({ref_valid, irq}, 2'h0)
		for (logic [9:0] i = ram_pkg::IDX_LOGIC; i <= ram_pkg::IDX_FDRAIN;
			i++) begin
			apb(1'b0, i, 8'h00);
			`chk(rdat, {24'h00_0000, ram_pkg::REG_RST_C[i]})
		end
		`chk(cfg.div2_en, 1'b0)
		`chk(cfg.family, 2'h0)
		`chk(cfg.rdiv, 20'h0_00CF)
		`chk(cfg.nom_period, 40'h00_0310_EAC9)
		`chk({cfg.inner_tol, cfg.outer_tol}, 40'h00_0140_000A)
		`chk(cfg.valid_time, 16'h000A)
		`chk(cfg.phase, 40'h00_02BC_0A0A)
		`chk(cfg.freq, 40'h00_02BC_0A0A)
		apb(1'b0, 10'h31B, 8'h00);
		`chk({rerr, rdat}, 33'h0_0000_0000 | 33'h1_0000_0000)
	endtask

	// Writable bits of every field, byte order of all but outer_tol, then defaults back.
	task t_fields;
		for (logic [9:0] i = ram_pkg::IDX_LOGIC; i <= ram_pkg::IDX_FDRAIN;
			i++) begin
			apb(1'b1, i, i[7:0] | 8'hF0);
			apb(1'b0, i, 8'h00);
			`chk(rdat[7:0], (i[7:0] | 8'hF0) & ram_pkg::REG_MASK_C[i])
		end
		`chk(cfg.rdiv, 20'h3_F2F1)
		`chk(cfg.nom_period, 40'hF8_F7F6_F5F4)
		`chk(cfg.inner_tol, 20'hB_FAF9)
		`chk(cfg.valid_time, 16'hF0FF)
		`chk(cfg.phase, 40'hF3_F2F1_F4F5)
		`chk(cfg.freq, 40'hF8_F7F6_F9FA)
		for (logic [9:0] i = ram_pkg::IDX_LOGIC; i <= ram_pkg::IDX_FDRAIN;
			i++) apb(1'b1, i, ram_pkg::REG_RST_C[i]);
	endtask

	// Count conditioned edges over 160 cycles (20 source periods).
	task rx(input logic [7:0] d, input logic cs, input int lo, hi);
		int r0;
		apb(1'b1, ram_pkg::IDX_LOGIC, d);
		src_comp <= cs;
		src_run <= 1'b1;
		repeat (4) @(posedge pclk);
		r0 = rises;
		repeat (160) @(posedge pclk);
		`chk((rises - r0) inside {[lo:hi]}, 1'b1)
		src_run <= 1'b0;
		@(posedge pclk);
	endtask

	// Lock detectors: fill counts, own thresholds, drain, interrupt.
	task t_lock;
		apb(1'b1, ram_pkg::IDX_PFILL, 8'h80);
		apb(1'b1, ram_pkg::IDX_FFILL, 8'h40);
		apb(1'b1, ram_pkg::IDX_PDRAIN, 8'h80);
		apb(1'b1, ram_pkg::IDX_FDRAIN, 8'h80);
		apb(1'b1, ram_pkg::IDX_IRQ_CLR, 8'h7F);
		apb(1'b1, ram_pkg::IDX_IRQ_EN, 8'h08);
		ticks(7, 24'h00_0100);
		`chk({phase_lock, irq}, 2'h0)
		ticks(1, 24'h00_0100);
		`chk({phase_lock, freq_lock, irq}, 3'h5)
		ticks(8, 24'h00_0100);
		`chk(freq_lock, 1'b1)
		apb(1'b0, ram_pkg::IDX_STATUS, 8'h00);
		`chk(rdat[6:3], 4'h5)
		apb(1'b1, ram_pkg::IDX_IRQ_CLR, 8'h08);
		`chk(irq, 1'b0)
		apb(1'b1, ram_pkg::IDX_IRQ_EN, 8'h10);
		ticks(7, 24'h00_02BC);
		`chk({phase_lock, freq_lock, irq}, 3'h6)
		ticks(1, 24'h00_02BC);
		`chk({phase_lock, freq_lock, irq}, 3'h1)
		apb(1'b1, ram_pkg::IDX_IRQ_EN, 8'h00);
		`chk(irq, 1'b0)
		apb(1'b1, ram_pkg::IDX_FTHR_B1, 8'h00);
		ticks(16, 24'h00_0100);
		`chk({phase_lock, freq_lock}, 2'h2)
	endtask

	// Frequency monitor hysteresis and validation time.
	task t_mon;
		apb(1'b1, ram_pkg::IDX_INNER_B0, 8'h14);
		apb(1'b1, ram_pkg::IDX_OUTER_B0, 8'h0A);
		apb(1'b1, ram_pkg::IDX_VTIME_B0, 8'h03);
		meas(nom + nom / 8);
		`chk({freq_fault, ref_valid}, 2'h2)
		meas(nom - nom / 16);
		`chk(freq_fault, 1'b1)
		meas(nom + nom / 32);
		`chk(freq_fault, 1'b0)
		repeat (12) @(posedge pclk);
		`chk(ref_valid, 1'b0)
		repeat (33) @(posedge pclk);
		`chk(ref_valid, 1'b1)
		meas(nom - nom / 8);
		`chk({freq_fault, ref_valid}, 2'h2)
	endtask

	// Watchdog.
	initial begin
		repeat (40000) @(posedge pclk);
		err_total++;
		end_sim;
	end

	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, pd_tick, meas_strobe} = 6'h00;
		{paddr, pwdata, phase_err_ps, freq_err_ps} = 92'h0;
		{meas_period_fs, src_run, src_comp} = 42'h0;
		{err_total, samples_checked} = 64'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_fields;
		rx(8'h00, 1'b0, 19, 21);
		rx(8'h08, 1'b0, 9, 11);
		rx(8'h00, 1'b1, 0, 0);
		for (int f = 1; f < 4; f++) rx(f[7:0], 1'b1, 19, 21);
		t_lock;
		t_mon;
		end_sim;
	end
endmodule // test_ref_input_a_monitor_config
